// ===== reference_level_pkg.sv
/*
  reference_level_pkg: register map, field layout, reset values, mode codes and the
  carrier structs of the comparator / reference control block.
  assumes: APB with 32-bit data; registers sit in the low byte of each word.
*/
`default_nettype none

package reference_level_pkg;

  // printed offsets are not all multiples of four: they are register indexes
  localparam logic [7:0] REFERENCE_LEVEL_IDX_COMPARATOR_CONTROL = 8'h9c;
  localparam logic [7:0] REFERENCE_LEVEL_IDX_REFERENCE_CONTROL = 8'h9d;
  localparam logic [7:0] REFERENCE_LEVEL_IDX_IRQ_STATUS = 8'ha0;
  localparam logic [7:0] REFERENCE_LEVEL_IDX_IRQ_CLEAR = 8'ha1;
  localparam logic [7:0] REFERENCE_LEVEL_IDX_IRQ_ENABLE = 8'ha2;
  localparam logic [7:0] REFERENCE_LEVEL_IDX_POWER_CTRL = 8'ha3;
  localparam int REFERENCE_LEVEL_ADDR_W = 12;
  localparam int REFERENCE_LEVEL_IDX_LSB = 2;

  // comparator_control fields
  localparam int CMP_MODE_LSB = 0;
  localparam int CMP_INPUT_SWITCH = 3;
  localparam int CMP_FIRST_INVERT = 4;
  localparam int CMP_SECOND_INVERT = 5;
  localparam int CMP_FIRST_RESULT = 6;
  localparam int CMP_SECOND_RESULT = 7;
  localparam logic [7:0] CMP_CTRL_RESET = 8'h07;
  localparam logic [7:0] CMP_CTRL_WMASK = 8'h3f;

  // reference_control fields
  localparam int REF_TAP_LSB = 0;
  localparam int REF_RANGE_BIT = 5;
  localparam int REF_PIN_BIT = 6;
  localparam int REF_POWER_BIT = 7;
  localparam logic [7:0] REF_CTRL_RESET = 8'h00;
  localparam logic [7:0] REF_CTRL_WMASK = 8'hef;

  // interrupt status / clear / enable layout
  localparam int IRQ_CHANGE_BIT = 0;
  localparam int IRQ_W = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 1'h0;

  // power control: bit 0 requests sleep
  localparam int PWR_SLEEP_BIT = 0;

  localparam int TAP_COUNT = 16;

  typedef enum logic [2:0] {
    REFERENCE_LEVEL_MODE_INT_REF = 3'h6,
    REFERENCE_LEVEL_MODE_OFF = 3'h7
  } reference_level_mode_codes_t;

  typedef struct packed {
    logic [7:0] comparator_control;
    logic [7:0] reference_control;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [1:0] latched_result;
    logic sleeping;
    logic [31:0] prdata;
  } reference_level_state_t;

  typedef struct packed {
    logic ref_power_on;
    logic ref_pin_drive_on;
    logic ref_range_select;
    logic [3:0] ref_tap_code;
    logic [15:0] tap_select;
    logic ref_to_comparators;
    logic [2:0] comparator_mode_field;
    logic input_switch_select;
  } reference_level_analog_ctrl_t;

endpackage : reference_level_pkg

`default_nettype wire

// ===== reference_level_ctrl.sv
/*
  reference_level_ctrl: digital control of a two-comparator unit and its 16-tap
  reference ladder, with an APB register slave and a change interrupt.
  assumes: raw comparator outputs arrive unsynchronised from the analog
  side; the analog side obeys the ladder and power controls given here.
*/
// The APB register port was chosen for this implementation.
`default_nettype none

module reference_level_ctrl (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] raw_compare,
  output reference_level_pkg::reference_level_analog_ctrl_t analog_ctrl,
  output logic sleep_active,
  output logic wake_request,
  output logic irq
);

  reference_level_pkg::reference_level_state_t state_r;
  reference_level_pkg::reference_level_state_t state_nxt;
  logic [1:0] cmp_meta_r;
  logic [1:0] cmp_sync_r;
  logic [1:0] reported;
  logic access;
  logic [7:0] idx;
  logic mapped;
  logic change_event;
  logic [2:0] mode;
  logic ref_used;
  logic setup;
  logic [7:0] read_byte;
  logic [reference_level_pkg::TAP_COUNT-1:0] analog_ctrl_tap;

  // the analog outputs are asynchronous to core_clk
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmp_meta_r <= 2'h0;
      cmp_sync_r <= 2'h0;
    end else begin
      cmp_meta_r <= raw_compare;
      cmp_sync_r <= cmp_meta_r;
    end
  end

  assign mode = state_r.comparator_control[reference_level_pkg::CMP_MODE_LSB +: 3];
  // off mode reports zero; otherwise result is raw xor invert bit
  always_comb begin
    reported = 2'h0;
    if (mode != reference_level_pkg::REFERENCE_LEVEL_MODE_OFF) begin
      reported[0] = cmp_sync_r[0] ^
        state_r.comparator_control[reference_level_pkg::CMP_FIRST_INVERT];
      reported[1] = cmp_sync_r[1] ^
        state_r.comparator_control[reference_level_pkg::CMP_SECOND_INVERT];
    end
  end

  assign access = psel & penable;
  // read data is captured in the setup cycle so that it already stands at
  // the access edge, where the master takes it with pready high
  assign setup = psel & ~penable;
  assign idx = paddr[reference_level_pkg::REFERENCE_LEVEL_IDX_LSB +: 8];
  assign mapped = (paddr[reference_level_pkg::REFERENCE_LEVEL_ADDR_W-1 -: 2] == 2'h0) &&
    (paddr[reference_level_pkg::REFERENCE_LEVEL_IDX_LSB-1:0] == 2'h0) &&
    ((idx == reference_level_pkg::REFERENCE_LEVEL_IDX_COMPARATOR_CONTROL) ||
     (idx == reference_level_pkg::REFERENCE_LEVEL_IDX_REFERENCE_CONTROL) ||
     (idx == reference_level_pkg::REFERENCE_LEVEL_IDX_IRQ_STATUS) ||
     (idx == reference_level_pkg::REFERENCE_LEVEL_IDX_IRQ_CLEAR) ||
     (idx == reference_level_pkg::REFERENCE_LEVEL_IDX_IRQ_ENABLE) ||
     (idx == reference_level_pkg::REFERENCE_LEVEL_IDX_POWER_CTRL));

  // mismatch between live result and the last value software saw; keeps
  // running in sleep since core_clk is assumed to stay on
  assign change_event = (reported != state_r.latched_result);

  // read multiplexer; unmapped addresses read as zero
  always_comb begin
    read_byte = 8'h00;
    if (mapped) begin
      case (idx)
        reference_level_pkg::REFERENCE_LEVEL_IDX_COMPARATOR_CONTROL: begin
          read_byte = {reported[1], reported[0],
            state_r.comparator_control[5:0]};
        end
        reference_level_pkg::REFERENCE_LEVEL_IDX_REFERENCE_CONTROL: begin
          read_byte = state_r.reference_control;
        end
        reference_level_pkg::REFERENCE_LEVEL_IDX_IRQ_STATUS: begin
          read_byte[reference_level_pkg::IRQ_W-1:0] = state_r.irq_status;
        end
        reference_level_pkg::REFERENCE_LEVEL_IDX_IRQ_ENABLE: begin
          read_byte[reference_level_pkg::IRQ_W-1:0] = state_r.irq_enable;
        end
        reference_level_pkg::REFERENCE_LEVEL_IDX_POWER_CTRL: begin
          read_byte[reference_level_pkg::PWR_SLEEP_BIT] = state_r.sleeping;
        end
        default: begin
          read_byte = 8'h00;
        end
      endcase
    end
  end

  always_comb begin
    state_nxt = state_r;
    // mismatch keeps setting the flag until a comparator_control access re-latches
    if (change_event) begin
      state_nxt.irq_status[reference_level_pkg::IRQ_CHANGE_BIT] = 1'b1;
    end
    if (setup) begin
      state_nxt.prdata = {24'h00_0000, read_byte};
    end
    // unmapped accesses answer with pslverr and change nothing
    if (access && mapped) begin
      case (idx)
        reference_level_pkg::REFERENCE_LEVEL_IDX_COMPARATOR_CONTROL: begin
          // any read or write ends the mismatch
          state_nxt.latched_result = reported;
          if (pwrite) begin
            state_nxt.comparator_control =
              pwdata[7:0] & reference_level_pkg::CMP_CTRL_WMASK;
          end
        end
        reference_level_pkg::REFERENCE_LEVEL_IDX_REFERENCE_CONTROL: begin
          if (pwrite) begin
            state_nxt.reference_control =
              pwdata[7:0] & reference_level_pkg::REF_CTRL_WMASK;
          end
        end
        reference_level_pkg::REFERENCE_LEVEL_IDX_IRQ_STATUS: begin
          state_nxt.latched_result = state_r.latched_result;
        end
        reference_level_pkg::REFERENCE_LEVEL_IDX_IRQ_CLEAR: begin
          // set wins over clear while a mismatch persists
          if (pwrite) begin
            state_nxt.irq_status = state_r.irq_status &
              ~pwdata[reference_level_pkg::IRQ_W-1:0];
            if (change_event) begin
              state_nxt.irq_status[reference_level_pkg::IRQ_CHANGE_BIT] = 1'b1;
            end
          end
        end
        reference_level_pkg::REFERENCE_LEVEL_IDX_IRQ_ENABLE: begin
          if (pwrite) begin
            state_nxt.irq_enable = pwdata[reference_level_pkg::IRQ_W-1:0];
          end
        end
        reference_level_pkg::REFERENCE_LEVEL_IDX_POWER_CTRL: begin
          if (pwrite) begin
            state_nxt.sleeping = pwdata[reference_level_pkg::PWR_SLEEP_BIT];
          end
        end
        default: begin
          state_nxt.latched_result = state_r.latched_result;
        end
      endcase
    end
    // wake leaves comparator_control alone, only sleep flag drops
    if (state_r.sleeping && |(state_r.irq_status & state_r.irq_enable)) begin
      state_nxt.sleeping = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r.comparator_control <= reference_level_pkg::CMP_CTRL_RESET;
      state_r.reference_control <= reference_level_pkg::REF_CTRL_RESET;
      state_r.irq_status <= reference_level_pkg::IRQ_RESET;
      state_r.irq_enable <= reference_level_pkg::IRQ_RESET;
      state_r.latched_result <= 2'h0;
      state_r.sleeping <= 1'b0;
      state_r.prdata <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign prdata = state_r.prdata;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign irq = |(state_r.irq_status & state_r.irq_enable);
  assign sleep_active = state_r.sleeping;
  assign wake_request = state_r.sleeping & irq;

  // reference is used whenever the power bit is set, whatever the mode
  assign ref_used =
    state_r.reference_control[reference_level_pkg::REF_POWER_BIT];

  always_comb begin
    analog_ctrl = '0;
    analog_ctrl.ref_power_on = ref_used;
    analog_ctrl.ref_pin_drive_on = ref_used &
      state_r.reference_control[reference_level_pkg::REF_PIN_BIT];
    // range 1: tap/24 of source; range 0: source/4 plus tap/32
    analog_ctrl.ref_range_select =
      state_r.reference_control[reference_level_pkg::REF_RANGE_BIT];
    analog_ctrl.ref_tap_code =
      state_r.reference_control[reference_level_pkg::REF_TAP_LSB +: 4];
    // internal ref drives non-inverting input of both comparators
    analog_ctrl.ref_to_comparators = ref_used &&
      (mode == reference_level_pkg::REFERENCE_LEVEL_MODE_INT_REF);
    analog_ctrl.comparator_mode_field = mode;
    analog_ctrl.input_switch_select =
      state_r.comparator_control[reference_level_pkg::CMP_INPUT_SWITCH];
    analog_ctrl.tap_select = analog_ctrl_tap;
  end

  // one-hot tap select into the sixteen-way selector; all off when down
  genvar t;
  generate
    for (t = 0; t < reference_level_pkg::TAP_COUNT; t++) begin : g_tap
      assign analog_ctrl_tap[t] = ref_used &&
        (state_r.reference_control[reference_level_pkg::REF_TAP_LSB +: 4] ==
         4'(t));
    end
  endgenerate

endmodule : reference_level_ctrl

`default_nettype wire

// ===== reference_level_ctrl_props.sv
/*
  reference_level_ctrl_props: port-level assertions for reference_level_ctrl.
  assumes: bound to every reference_level_ctrl instance; one clock, async reset.
*/
`default_nettype none
module reference_level_ctrl_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] raw_compare,
  input wire reference_level_pkg::reference_level_analog_ctrl_t analog_ctrl,
  input wire logic sleep_active,
  input wire logic wake_request,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic acc;
  logic [3:0] wtap;
  logic [2:0] wmode;
  logic wrng;
  logic wpwr;
  assign acc = psel && penable && pwrite;
  assign wtap = pwdata[3:0];
  assign wmode = pwdata[2:0];
  assign wrng = pwdata[5];
  assign wpwr = pwdata[7];
  chk_wake_level: assert property (
    wake_request == (sleep_active && irq)) else $error("wake level wrong");
  chk_ref_gate: assert property (
    analog_ctrl.ref_to_comparators == (analog_ctrl.ref_power_on &&
    analog_ctrl.comparator_mode_field == 3'h6)) else $error("ref gate wrong");
  chk_pin_gate: assert property (
    analog_ctrl.ref_pin_drive_on |-> analog_ctrl.ref_power_on)
    else $error("pin driven while powered down");
  chk_wake_clear: assert property (
    sleep_active && irq |-> ##[1:2] !sleep_active) else $error("no wake");
  chk_sleep_keep: assert property (
    $fell(sleep_active) && !$past(psel) |->
    $stable(analog_ctrl.comparator_mode_field) &&
    $stable(analog_ctrl.input_switch_select)) else $error("wake altered mode");
  chk_reset_off: assert property (
    $fell(rst) |-> analog_ctrl.comparator_mode_field == 3'h7 &&
    !analog_ctrl.ref_power_on) else $error("reset state wrong");
  chk_ref_write: assert property (
    acc && paddr == 12'h274 |=> analog_ctrl.ref_tap_code == $past(wtap) &&
    analog_ctrl.ref_range_select == $past(wrng) &&
    analog_ctrl.ref_power_on == $past(wpwr)) else $error("ref write lost");
  chk_mode_write: assert property (
    acc && paddr == 12'h270 |=>
    analog_ctrl.comparator_mode_field == $past(wmode))
    else $error("mode write lost");
  chk_tap_onehot: assert property (
    analog_ctrl.ref_power_on |->
    analog_ctrl.tap_select == (16'h0001 << analog_ctrl.ref_tap_code))
    else $error("tap select wrong");
  chk_tap_idle: assert property (
    !analog_ctrl.ref_power_on |-> analog_ctrl.tap_select == 16'h0000)
    else $error("tap select active while down");
endmodule : reference_level_ctrl_props
bind reference_level_ctrl reference_level_ctrl_props u_props (.core_clk(core_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .raw_compare(raw_compare), .analog_ctrl(analog_ctrl),
  .sleep_active(sleep_active), .wake_request(wake_request), .irq(irq));
`default_nettype wire

// ===== reference_level_ctrl_tb.sv
/*
  reference_level_ctrl_tb: directed bench for reference_level_ctrl over APB.
  assumes: read data and pslverr stand at the edge where pready is high.
*/
`default_nettype none
module reference_level_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_CMP = 12'h270;
  localparam logic [11:0] A_REF = 12'h274;
  localparam logic [11:0] A_ST = 12'h280;
  localparam logic [11:0] A_CLR = 12'h284;
  localparam logic [11:0] A_EN = 12'h288;
  localparam logic [11:0] A_PWR = 12'h28c;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, lrd;
  logic pready, pslverr, lerr, sleep_active, wake_request, irq;
  logic [1:0] raw_compare = 0;
  reference_level_pkg::reference_level_analog_ctrl_t ac;
  int error_cnt = 0, checks = 0;
  always #4 core_clk = ~core_clk;
  reference_level_ctrl dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .raw_compare(raw_compare), .analog_ctrl(ac),
    .sleep_active(sleep_active), .wake_request(wake_request), .irq(irq));
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= 32'(d);
    @(posedge core_clk);
    penable <= 1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 50) error_cnt++;
    lrd = prdata;
    lerr = pslverr;
    psel <= 0;
    penable <= 0;
    // let the write settle before the caller looks at outputs
    @(negedge core_clk);
  endtask : bus
  task automatic settle(input logic [1:0] r);
    @(posedge core_clk);
    raw_compare <= r;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle
  task automatic t_reset;
    bus(0, A_CMP, 8'h00); cmp8(lrd[7:0], 8'h07);
    bus(0, A_REF, 8'h00); cmp8(lrd[7:0], 8'h00);
    cmp8(8'({irq, sleep_active}), 8'h00);
  endtask : t_reset
  task automatic t_ref;
    bus(1, A_REF, 8'hff); bus(0, A_REF, 8'h00); cmp8(lrd[7:0], 8'hef);
    cmp8(8'({ac.ref_power_on, ac.ref_pin_drive_on}), 8'h03);
    for (int t = 0; t < 16; t++) begin
      bus(1, A_REF, 8'(t) | 8'h80);
      cmp8(8'({ac.ref_range_select, ac.ref_tap_code}), 8'(t));
    end
    bus(1, A_REF, 8'h6a);
    cmp8(8'({ac.ref_power_on, ac.ref_to_comparators}), 8'h00);
  endtask : t_ref
  task automatic t_mode;
    bus(1, A_REF, 8'h80); bus(1, A_CMP, 8'h06);
    cmp8(8'(ac.ref_to_comparators), 8'h01);
    bus(1, A_CMP, 8'hc7); bus(0, A_CMP, 8'h00); cmp8(lrd[7:0], 8'h07);
  endtask : t_mode
  task automatic t_irq;
    bus(1, A_EN, 8'h01); bus(1, A_CMP, 8'h06);
    settle(2'b01); cmp8(8'(irq), 8'h01);
    bus(0, A_CMP, 8'h00); cmp8(lrd[7:0], 8'h46);
    bus(1, A_CLR, 8'h01); bus(0, A_ST, 8'h00); cmp8(lrd[7:0], 8'h00);
    bus(1, A_CMP, 8'h16); bus(0, A_CMP, 8'h00); cmp8(lrd[7:0], 8'h16);
    bus(1, A_CLR, 8'h01); bus(1, A_EN, 8'h00);
    settle(2'b00); bus(1, A_CLR, 8'h01);
    // mismatch not ended by a status access, so the flag comes back
    bus(0, A_ST, 8'h00); cmp8(lrd[7:0], 8'h01);
    cmp8(8'(irq), 8'h00);
    bus(0, A_CMP, 8'h00); bus(1, A_CLR, 8'h01);
  endtask : t_irq
  task automatic t_sleep;
    bus(1, A_EN, 8'h01); bus(1, A_PWR, 8'h01);
    cmp8(8'(sleep_active), 8'h01);
    settle(2'b10); cmp8(8'(sleep_active), 8'h00);
    bus(0, A_CMP, 8'h00); cmp8(lrd[7:0], 8'hd6);
    bus(1, A_CMP, 8'h07); bus(0, A_CMP, 8'h00); bus(1, A_CLR, 8'h01);
    bus(1, A_PWR, 8'h01); settle(2'b01);
    cmp8(8'(sleep_active), 8'h01);
    bus(1, A_PWR, 8'h00);
  endtask : t_sleep
  task automatic t_unmapped;
    bus(1, 12'h300, 8'hff); cmp8(8'(lerr), 8'h01);
    bus(0, 12'h300, 8'h00); cmp8(lrd[7:0], 8'h00);
  endtask : t_unmapped
  task automatic report_and_stop;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 0;
    t_reset(); t_ref(); t_mode(); t_irq(); t_sleep(); t_unmapped();
    @(posedge core_clk);
    rst <= 1;
    repeat (3) @(posedge core_clk);
    rst <= 0;
    t_reset();
    report_and_stop();
  end
endmodule : reference_level_ctrl_tb
`default_nettype wire
